// [inc/ifp_map.vh]
// Register indexes, field positions, bit masks and reset values
`ifndef IFP_MAP_VH
`define IFP_MAP_VH

// ********************************************************************
// Register indexes (byte address is four times the index)
// ********************************************************************
`define IFP_IDX_POL 8'hf9
`define IFP_IDX_REQ1 8'hfc
`define IFP_IDX_EN2 8'hff
`define IFP_IDX_EN1 8'h10
`define IFP_IDX_REQ2 8'h11
`define IFP_IDX_STAT 8'h12
`define IFP_IDX_MASK 8'h13

// ********************************************************************
// Field positions
// ********************************************************************
`define IFP_POL_EXT1 3
`define IFP_POL_EXT2 4
`define IFP_POL_EXT3 5
`define IFP_REQ1_EXT3 7
`define IFP_EN2_EXT1 0
`define IFP_EN2_EXT2 1
`define IFP_EN2_SERIAL 2
`define IFP_EN2_TICK 4

// ********************************************************************
// Writable and readable bit masks
// ********************************************************************
`define IFP_POL_WMASK 8'hbe
`define IFP_REQ1_MASK 8'hbf
`define IFP_REQ2_MASK 8'h17

// ********************************************************************
// Reset values
// ********************************************************************
`define IFP_POL_RST 8'h00
`define IFP_REQ1_RST 8'h00
`define IFP_EN2_RST 8'h00
`define IFP_EN1_RST 8'h00
`define IFP_REQ2_RST 8'h00
`define IFP_STAT_RST 16'h0000
`define IFP_MASK_RST 16'h0000

// ********************************************************************
// Timing
// ********************************************************************
`define IFP_TICK_CYCLES 4096
`define IFP_TICK_LAST 12'hfff

// ********************************************************************
// Bus responses
// ********************************************************************
`define IFP_RESP_OKAY 2'b00
`define IFP_RESP_SLVERR 2'b10

`endif

// [hdl/ifp_edge.v]
// Pin synchroniser with polarity-selected edge detector
`timescale 1ns/1ps
module ifp_edge (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_pin,
  input wire i_negative,
  output reg o_event
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // ******************************************************************
  // Two-flop synchroniser, previous level and edge pulse
  // ******************************************************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      o_event <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      if (i_negative) begin
        o_event <= prev_reg & ~sync_reg;
      end else begin
        o_event <= ~prev_reg & sync_reg;
      end
    end
  end
endmodule

// [hdl/ifp_axil.v]
// AXI4-Lite slave front end with single write and read in flight
`timescale 1ns/1ps
`include "ifp_map.vh"
module ifp_axil (
  input wire i_clk,
  input wire i_rst_n,
  input wire [11:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [11:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output wire o_wr_pulse,
  output reg [11:0] o_wr_addr,
  output reg [31:0] o_wr_data,
  output reg [3:0] o_wr_strb,
  input wire i_wr_ok,
  output wire o_rd_pulse,
  input wire [31:0] i_rd_data,
  input wire i_rd_ok
);
  reg aw_full_reg;
  reg w_full_reg;

  assign o_awready = ~aw_full_reg & ~o_bvalid;
  assign o_wready = ~w_full_reg & ~o_bvalid;
  assign o_wr_pulse = aw_full_reg & w_full_reg & ~o_bvalid;
  assign o_arready = ~o_rvalid;
  assign o_rd_pulse = i_arvalid & ~o_rvalid;

  // ******************************************************************
  // Write channels
  // ******************************************************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      o_wr_addr <= 12'h000;
      o_wr_data <= 32'h0000_0000;
      o_wr_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `IFP_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full_reg <= 1'b1;
        o_wr_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full_reg <= 1'b1;
        o_wr_data <= i_wdata;
        o_wr_strb <= i_wstrb;
      end
      if (o_wr_pulse) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= i_wr_ok ? `IFP_RESP_OKAY : `IFP_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Read channels
  // ******************************************************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `IFP_RESP_OKAY;
    end else begin
      if (o_rd_pulse) begin
        o_rvalid <= 1'b1;
        o_rdata <= i_rd_data;
        o_rresp <= i_rd_ok ? `IFP_RESP_OKAY : `IFP_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule

// [hdl/ifp_top.v]
// Interrupt polarity, request flags and enables behind an AXI4-Lite slave
//
// Contract
// - INT-A edge rising at 0, falling at 1
// - INT-B polarity bit four, reset zero
// - INT-C polarity bit five, reset zero
// - Polarity bit zero ignores writes, reads undefined
// - Request bits 0-3 flag timers one-four
// - Request bit four flags display event
// - Request bit five flags vertical sync
// - Request bit seven INT-C; bit six zero
// - Flag reads one while request pending
// - Enable bits 0,1 gate INT-A, INT-B
// - Enable bit two gates serial port
// - Enable bit four gates 4096-cycle tick
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "ifp_map.vh"
module ifp_top (
  input wire I_SYS_CLK,
  input wire I_ARST_N,
  input wire [11:0] I_S_AXI_AWADDR,
  input wire I_S_AXI_AWVALID,
  output wire O_S_AXI_AWREADY,
  input wire [31:0] I_S_AXI_WDATA,
  input wire [3:0] I_S_AXI_WSTRB,
  input wire I_S_AXI_WVALID,
  output wire O_S_AXI_WREADY,
  output wire [1:0] O_S_AXI_BRESP,
  output wire O_S_AXI_BVALID,
  input wire I_S_AXI_BREADY,
  input wire [11:0] I_S_AXI_ARADDR,
  input wire I_S_AXI_ARVALID,
  output wire O_S_AXI_ARREADY,
  output wire [31:0] O_S_AXI_RDATA,
  output wire [1:0] O_S_AXI_RRESP,
  output wire O_S_AXI_RVALID,
  input wire I_S_AXI_RREADY,
  input wire I_TIMER_ONE_EVENT,
  input wire I_TIMER_TWO_EVENT,
  input wire I_TIMER_THREE_EVENT,
  input wire I_TIMER_FOUR_EVENT,
  input wire I_DISPLAY_EVENT,
  input wire I_VERTICAL_SYNC_EVENT,
  input wire I_SERIAL_EVENT,
  input wire I_EXTERNAL_INTERRUPT_INPUT_A,
  input wire I_EXTERNAL_INTERRUPT_INPUT_B,
  input wire I_EXTERNAL_INTERRUPT_INPUT_C,
  output reg O_CPU_IRQ,
  output reg O_IRQ
);

  // ******************************************************************
  // Functions
  // ******************************************************************
  function hit;
    input [11:0] addr;
    input [7:0] idx;
    begin
      hit = (addr[11:10] == 2'b00) && (addr[9:2] == idx);
    end
  endfunction

  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      flag_next = (cur & ~clr) | set;
    end
  endfunction

  // ******************************************************************
  // Reset release
  // ******************************************************************
  reg rst_meta_reg;
  reg rst_n_reg;

  always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ******************************************************************
  // Declarations
  // ******************************************************************
  reg [7:0] pol_reg;
  reg [7:0] req1_reg;
  reg [7:0] en2_reg;
  reg [7:0] en1_reg;
  reg [7:0] req2_reg;
  reg [15:0] stat_reg;
  reg [15:0] mask_reg;
  reg [11:0] tick_cnt_reg;
  reg tick_reg;
  reg [31:0] rd_data;
  reg rd_ok;
  reg wr_ok;
  wire wr_pulse;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_pulse;
  wire ext1_event;
  wire ext2_event;
  wire ext3_event;
  wire [7:0] req1_set;
  wire [7:0] req2_set;
  wire [7:0] req1_clr;
  wire [7:0] req2_clr;
  wire [15:0] stat_set;
  wire [15:0] stat_clr;
  wire lane0;
  wire lane1;

  // ******************************************************************
  // Bus slave
  // ******************************************************************
  ifp_axil u_axil (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n_reg),
    .i_awaddr(I_S_AXI_AWADDR),
    .i_awvalid(I_S_AXI_AWVALID),
    .o_awready(O_S_AXI_AWREADY),
    .i_wdata(I_S_AXI_WDATA),
    .i_wstrb(I_S_AXI_WSTRB),
    .i_wvalid(I_S_AXI_WVALID),
    .o_wready(O_S_AXI_WREADY),
    .o_bresp(O_S_AXI_BRESP),
    .o_bvalid(O_S_AXI_BVALID),
    .i_bready(I_S_AXI_BREADY),
    .i_araddr(I_S_AXI_ARADDR),
    .i_arvalid(I_S_AXI_ARVALID),
    .o_arready(O_S_AXI_ARREADY),
    .o_rdata(O_S_AXI_RDATA),
    .o_rresp(O_S_AXI_RRESP),
    .o_rvalid(O_S_AXI_RVALID),
    .i_rready(I_S_AXI_RREADY),
    .o_wr_pulse(wr_pulse),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .i_wr_ok(wr_ok),
    .o_rd_pulse(rd_pulse),
    .i_rd_data(rd_data),
    .i_rd_ok(rd_ok)
  );

  assign lane0 = wr_pulse & wr_strb[0];
  assign lane1 = wr_pulse & wr_strb[1];

  // ******************************************************************
  // External pins
  // ******************************************************************
  ifp_edge u_ext1 (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n_reg),
    .i_pin(I_EXTERNAL_INTERRUPT_INPUT_A),
    .i_negative(pol_reg[`IFP_POL_EXT1]),
    .o_event(ext1_event)
  );

  ifp_edge u_ext2 (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n_reg),
    .i_pin(I_EXTERNAL_INTERRUPT_INPUT_B),
    .i_negative(pol_reg[`IFP_POL_EXT2]),
    .o_event(ext2_event)
  );

  ifp_edge u_ext3 (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n_reg),
    .i_pin(I_EXTERNAL_INTERRUPT_INPUT_C),
    .i_negative(pol_reg[`IFP_POL_EXT3]),
    .o_event(ext3_event)
  );

  // ******************************************************************
  // Divided-clock tick
  // ******************************************************************
  always @(posedge I_SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tick_cnt_reg <= 12'h000;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 12'h001;
      tick_reg <= (tick_cnt_reg == `IFP_TICK_LAST);
    end
  end

  // ******************************************************************
  // Event sets and software clears
  // ******************************************************************
  assign req1_set = {ext3_event,
                     1'b0,
                     I_VERTICAL_SYNC_EVENT,
                     I_DISPLAY_EVENT,
                     I_TIMER_FOUR_EVENT,
                     I_TIMER_THREE_EVENT,
                     I_TIMER_TWO_EVENT,
                     I_TIMER_ONE_EVENT};

  assign req2_set = {3'b000, tick_reg, 1'b0, I_SERIAL_EVENT, ext2_event, ext1_event};

  assign req1_clr = (lane0 && hit(wr_addr, `IFP_IDX_REQ1)) ? ~wr_data[7:0] : 8'h00;
  assign req2_clr = (lane0 && hit(wr_addr, `IFP_IDX_REQ2)) ? ~wr_data[7:0] : 8'h00;

  assign stat_set = {req2_set, req1_set};
  assign stat_clr = (rd_pulse && hit(I_S_AXI_ARADDR, `IFP_IDX_STAT)) ? 16'hffff : 16'h0000;

  // ******************************************************************
  // Request flags
  // ******************************************************************
  always @(posedge I_SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      req1_reg <= `IFP_REQ1_RST;
      req2_reg <= `IFP_REQ2_RST;
    end else begin
      req1_reg <= flag_next(req1_reg, req1_set, req1_clr) & `IFP_REQ1_MASK;
      req2_reg <= flag_next(req2_reg, req2_set, req2_clr) & `IFP_REQ2_MASK;
    end
  end

  // ******************************************************************
  // Control registers
  // ******************************************************************
  always @(posedge I_SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pol_reg <= `IFP_POL_RST;
      en2_reg <= `IFP_EN2_RST;
      en1_reg <= `IFP_EN1_RST;
      mask_reg <= `IFP_MASK_RST;
    end else begin
      if (lane0 && hit(wr_addr, `IFP_IDX_POL)) begin
        pol_reg <= wr_data[7:0] & `IFP_POL_WMASK;
      end
      if (lane0 && hit(wr_addr, `IFP_IDX_EN2)) begin
        en2_reg <= wr_data[7:0];
      end
      if (lane0 && hit(wr_addr, `IFP_IDX_EN1)) begin
        en1_reg <= wr_data[7:0] & `IFP_REQ1_MASK;
      end
      if (lane0 && hit(wr_addr, `IFP_IDX_MASK)) begin
        mask_reg[7:0] <= wr_data[7:0];
      end
      if (lane1 && hit(wr_addr, `IFP_IDX_MASK)) begin
        mask_reg[15:8] <= wr_data[15:8];
      end
    end
  end

  // ******************************************************************
  // Sticky status and interrupt outputs
  // ******************************************************************
  always @(posedge I_SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      stat_reg <= `IFP_STAT_RST;
      O_CPU_IRQ <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      O_CPU_IRQ <= (|(req1_reg & en1_reg)) | (|(req2_reg & en2_reg));
      O_IRQ <= |(stat_reg & mask_reg);
    end
  end

  // ******************************************************************
  // Write decode
  // ******************************************************************
  always @* begin
    wr_ok = hit(wr_addr, `IFP_IDX_POL) | hit(wr_addr, `IFP_IDX_REQ1) |
            hit(wr_addr, `IFP_IDX_EN2) | hit(wr_addr, `IFP_IDX_EN1) |
            hit(wr_addr, `IFP_IDX_REQ2) | hit(wr_addr, `IFP_IDX_STAT) |
            hit(wr_addr, `IFP_IDX_MASK);
  end

  // ******************************************************************
  // Read decode
  // ******************************************************************
  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(I_S_AXI_ARADDR, `IFP_IDX_POL)) begin
      rd_data[7:0] = pol_reg;
    end else if (hit(I_S_AXI_ARADDR, `IFP_IDX_REQ1)) begin
      rd_data[7:0] = req1_reg;
    end else if (hit(I_S_AXI_ARADDR, `IFP_IDX_EN2)) begin
      rd_data[7:0] = en2_reg;
    end else if (hit(I_S_AXI_ARADDR, `IFP_IDX_EN1)) begin
      rd_data[7:0] = en1_reg;
    end else if (hit(I_S_AXI_ARADDR, `IFP_IDX_REQ2)) begin
      rd_data[7:0] = req2_reg;
    end else if (hit(I_S_AXI_ARADDR, `IFP_IDX_STAT)) begin
      rd_data[15:0] = stat_reg;
    end else if (hit(I_S_AXI_ARADDR, `IFP_IDX_MASK)) begin
      rd_data[15:0] = mask_reg;
    end else begin
      rd_ok = 1'b0;
    end
  end
endmodule

// [verif/ifp_src.sv]
// Event source and external pin model
`timescale 1ns/1ps
module ifp_src (
  input wire i_clk,
  output reg [6:0] o_evt,
  output reg [2:0] o_pin
);
  initial begin
    o_evt = 7'h0;
    o_pin = 3'h0;
  end
  // One-cycle event pulse
  task pulse(input integer k);
    begin
      @(posedge i_clk);
      o_evt[k] <= 1'b1;
      @(posedge i_clk);
      o_evt[k] <= 1'b0;
    end
  endtask
  // Pin change, then settle past the synchroniser
  task pin(input integer k, input v);
    begin
      @(posedge i_clk);
      o_pin[k] <= v;
      repeat (8) @(posedge i_clk);
    end
  endtask
endmodule

// [verif/ifp_assertions.sv]
// Bus handshake and read data checks on the top-level ports
`timescale 1ns/1ps
module ifp_checker (
  input wire I_SYS_CLK,
  input wire I_ARST_N,
  input wire I_S_AXI_AWVALID,
  input wire O_S_AXI_AWREADY,
  input wire I_S_AXI_WVALID,
  input wire O_S_AXI_WREADY,
  input wire [1:0] O_S_AXI_BRESP,
  input wire O_S_AXI_BVALID,
  input wire I_S_AXI_BREADY,
  input wire [11:0] I_S_AXI_ARADDR,
  input wire I_S_AXI_ARVALID,
  input wire O_S_AXI_ARREADY,
  input wire [31:0] O_S_AXI_RDATA,
  input wire [1:0] O_S_AXI_RRESP,
  input wire O_S_AXI_RVALID,
  input wire I_S_AXI_RREADY
);
  reg [11:0] rd_addr_reg;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);
  // Address of the read in flight
  always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) rd_addr_reg <= 12'h0;
    else if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) rd_addr_reg <= I_S_AXI_ARADDR;
  end
  // ********************
  // Properties
  // ********************
  a_read_latency: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID)
    else $error("read answer late");
  a_rvalid_hold: assert property (O_S_AXI_RVALID && !I_S_AXI_RREADY |=>
    O_S_AXI_RVALID && $stable(O_S_AXI_RDATA) && $stable(O_S_AXI_RRESP))
    else $error("read answer not held");
  a_rvalid_drop: assert property (O_S_AXI_RVALID && I_S_AXI_RREADY |=> !O_S_AXI_RVALID)
    else $error("read answer repeated");
  a_ar_refused: assert property (O_S_AXI_RVALID |-> !O_S_AXI_ARREADY)
    else $error("read taken while answer pending");
  a_write_answer: assert property (I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID
    && O_S_AXI_WREADY |-> ##2 O_S_AXI_BVALID)
    else $error("write answer late");
  a_bvalid_hold: assert property (O_S_AXI_BVALID && !I_S_AXI_BREADY |=>
    O_S_AXI_BVALID && $stable(O_S_AXI_BRESP))
    else $error("write answer not held");
  a_bvalid_drop: assert property (O_S_AXI_BVALID && I_S_AXI_BREADY |=> !O_S_AXI_BVALID)
    else $error("write answer repeated");
  a_aw_refused: assert property (O_S_AXI_BVALID |-> !O_S_AXI_AWREADY && !O_S_AXI_WREADY)
    else $error("write taken while answer pending");
  a_pol_unused: assert property (O_S_AXI_RVALID && rd_addr_reg == 12'h3e4 |->
    O_S_AXI_RDATA[0] == 1'b0 && O_S_AXI_RDATA[6] == 1'b0) else $error("polarity spare set");
  a_req_unused: assert property (O_S_AXI_RVALID && rd_addr_reg == 12'h3f0 |->
    O_S_AXI_RDATA[6] == 1'b0 && O_S_AXI_RDATA[31:8] == 24'h0) else $error("request spare set");
  a_unmapped_read: assert property (O_S_AXI_RVALID && rd_addr_reg[11:10] != 2'h0 |->
    O_S_AXI_RRESP == 2'h2 && O_S_AXI_RDATA == 32'h0) else $error("unmapped read answered");
endmodule
bind ifp_top ifp_checker chk (.I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N),
  .I_S_AXI_AWVALID(I_S_AXI_AWVALID), .O_S_AXI_AWREADY(O_S_AXI_AWREADY),
  .I_S_AXI_WVALID(I_S_AXI_WVALID), .O_S_AXI_WREADY(O_S_AXI_WREADY),
  .O_S_AXI_BRESP(O_S_AXI_BRESP), .O_S_AXI_BVALID(O_S_AXI_BVALID),
  .I_S_AXI_BREADY(I_S_AXI_BREADY), .I_S_AXI_ARADDR(I_S_AXI_ARADDR),
  .I_S_AXI_ARVALID(I_S_AXI_ARVALID), .O_S_AXI_ARREADY(O_S_AXI_ARREADY),
  .O_S_AXI_RDATA(O_S_AXI_RDATA), .O_S_AXI_RRESP(O_S_AXI_RRESP),
  .O_S_AXI_RVALID(O_S_AXI_RVALID), .I_S_AXI_RREADY(I_S_AXI_RREADY));

// [verif/testbench.sv]
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
  fail_count = fail_count + 1; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  localparam [11:0] A_POL = 12'h3e4;
  localparam [11:0] A_REQ1 = 12'h3f0;
  localparam [11:0] A_EN2 = 12'h3fc;
  localparam [11:0] A_EN1 = 12'h040;
  localparam [11:0] A_REQ2 = 12'h044;
  localparam [11:0] A_STAT = 12'h048;
  localparam [11:0] A_MASK = 12'h04c;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [11:0] awaddr = 12'h0, araddr = 12'h0;
  reg [31:0] wdata = 32'h0, acc, mb;
  reg [3:0] wstrb = 4'h0;
  reg [11:0] ra;
  wire awready, wready, bvalid, arready, rvalid, cpu_irq, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [6:0] evt;
  wire [2:0] pin;
  integer fail_count = 0, total_checks = 0, p, q;
  always #20 clk = ~clk;
  ifp_src src (.i_clk(clk), .o_evt(evt), .o_pin(pin));
  ifp_top dut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_S_AXI_AWADDR(awaddr),
    .I_S_AXI_AWVALID(awvalid), .O_S_AXI_AWREADY(awready), .I_S_AXI_WDATA(wdata),
    .I_S_AXI_WSTRB(wstrb), .I_S_AXI_WVALID(wvalid), .O_S_AXI_WREADY(wready),
    .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready),
    .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arvalid), .O_S_AXI_ARREADY(arready),
    .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid),
    .I_S_AXI_RREADY(rready), .I_TIMER_ONE_EVENT(evt[0]), .I_TIMER_TWO_EVENT(evt[1]),
    .I_TIMER_THREE_EVENT(evt[2]), .I_TIMER_FOUR_EVENT(evt[3]), .I_DISPLAY_EVENT(evt[4]),
    .I_VERTICAL_SYNC_EVENT(evt[5]), .I_SERIAL_EVENT(evt[6]),
    .I_EXTERNAL_INTERRUPT_INPUT_A(pin[0]), .I_EXTERNAL_INTERRUPT_INPUT_B(pin[1]),
    .I_EXTERNAL_INTERRUPT_INPUT_C(pin[2]), .O_CPU_IRQ(cpu_irq), .O_IRQ(irq));
  // ********************
  // Bus tasks
  // ********************
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    integer n;
    begin
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      @(posedge clk);
      while (!(bvalid && bready) && n < 200) begin
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) bready <= 1'b1;
        @(posedge clk);
        n = n + 1;
      end
      bready <= 1'b0;
      `CHK(bresp, er)
    end
  endtask
  task rd(input [11:0] a, input [31:0] e, input [31:0] m, input [1:0] er);
    integer n;
    begin
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge clk);
      while (!(rvalid && rready) && n < 200) begin
        if (arready) arvalid <= 1'b0;
        if (rvalid) rready <= 1'b1;
        @(posedge clk);
        n = n + 1;
      end
      rready <= 1'b0;
      `CHK(rdata & m, e)
      `CHK(rresp, er)
    end
  endtask
  task w2;
    repeat (2) @(posedge clk);
  endtask
  task tdone(input integer t);
    $display("test %0d done", t);
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count = fail_count + 1;
    close_out;
  end
  // ********************
  // Tests
  // ********************
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_POL, 32'h0, 32'hfe, 2'h0);
    rd(A_REQ1, 32'h0, 32'hff, 2'h0);
    rd(A_EN2, 32'h0, 32'hff, 2'h0);
    tdone(1);
    wr(A_POL, 32'h39, 4'h1, 2'h0);
    rd(A_POL, 32'h38, 32'hff, 2'h0);
    wr(A_EN2, 32'h17, 4'h1, 2'h0);
    rd(A_EN2, 32'h17, 32'hff, 2'h0);
    wr(A_EN2, 32'h0, 4'h1, 2'h0);
    wr(12'h100, 32'hff, 4'hf, 2'h2);
    rd(12'h800, 32'h0, 32'hffff_ffff, 2'h2);
    wr(A_POL, 32'h0, 4'h1, 2'h0);
    repeat (8) @(posedge clk);
    wr(A_REQ1, 32'h0, 4'h1, 2'h0);
    tdone(2);
    acc = 32'h0;
    for (p = 0; p < 6; p = p + 1) begin
      src.pulse(p);
      acc = acc | (32'h1 << p);
      rd(A_REQ1, acc, 32'hff, 2'h0);
    end
    wr(A_REQ1, 32'hf0, 4'h1, 2'h0);
    rd(A_REQ1, 32'h30, 32'hff, 2'h0);
    wr(A_REQ1, 32'h0, 4'h1, 2'h0);
    rd(A_REQ1, 32'h0, 32'hff, 2'h0);
    tdone(3);
    rd(A_STAT, 32'h3f, 32'hffff_ffff, 2'h0);
    src.pulse(0);
    w2;
    `CHK(irq, 1'b0)
    wr(A_MASK, 32'h1, 4'h3, 2'h0);
    w2;
    `CHK(irq, 1'b1)
    rd(A_STAT, 32'h1, 32'hff, 2'h0);
    w2;
    `CHK(irq, 1'b0)
    `CHK(cpu_irq, 1'b0)
    wr(A_EN1, 32'h1, 4'h1, 2'h0);
    w2;
    `CHK(cpu_irq, 1'b1)
    wr(A_REQ1, 32'h0, 4'h1, 2'h0);
    w2;
    `CHK(cpu_irq, 1'b0)
    wr(A_EN1, 32'h0, 4'h1, 2'h0);
    tdone(4);
    src.pulse(6);
    rd(A_REQ2, 32'h4, 32'h4, 2'h0);
    `CHK(cpu_irq, 1'b0)
    wr(A_EN2, 32'h4, 4'h1, 2'h0);
    w2;
    `CHK(cpu_irq, 1'b1)
    wr(A_REQ2, 32'h0, 4'h1, 2'h0);
    w2;
    `CHK(cpu_irq, 1'b0)
    wr(A_EN2, 32'h0, 4'h1, 2'h0);
    tdone(5);
    for (p = 0; p < 3; p = p + 1) begin
      for (q = 0; q < 2; q = q + 1) begin
        ra = (p == 2) ? A_REQ1 : A_REQ2;
        mb = (p == 2) ? 32'h80 : (32'h1 << p);
        wr(A_POL, (q == 1) ? (32'h8 << p) : 32'h0, 4'h1, 2'h0);
        src.pin(p, q == 0);
        wr(ra, 32'h0, 4'h1, 2'h0);
        src.pin(p, q == 1);
        rd(ra, 32'h0, mb, 2'h0);
        src.pin(p, q == 0);
        rd(ra, mb, mb, 2'h0);
        if (p < 2) begin
          wr(A_EN2, mb, 4'h1, 2'h0);
          w2;
          `CHK(cpu_irq, 1'b1)
          wr(A_EN2, 32'h0, 4'h1, 2'h0);
        end
        wr(ra, 32'h0, 4'h1, 2'h0);
      end
    end
    tdone(6);
    wr(A_REQ2, 32'h0, 4'h1, 2'h0);
    repeat (4100) @(posedge clk);
    rd(A_REQ2, 32'h10, 32'h10, 2'h0);
    wr(A_EN2, 32'h10, 4'h1, 2'h0);
    w2;
    `CHK(cpu_irq, 1'b1)
    tdone(7);
    close_out;
  end
endmodule
